// ### fcs_pkg.sv
// shared constants and carriers for the fabric flow-control status block
package fcs_pkg;

    // status message layout
    localparam int MSG_W = 27;
    localparam logic [1:0] KIND_IDLE = 2'h3;
    localparam logic KIND_CLASS = 1'b0;
    localparam logic [23:0] IDLE_BODY = 24'h000000;
    localparam logic [3:0] SUBPORT_NONE = 4'h0;

    // response timing, in ticks of half a clock
    localparam int C_TICKS = 192;
    localparam int SEG_TICKS_DEF = 34;
    localparam int TICKS_PER_CYCLE = 2;
    localparam logic [1:0] FRAME_ERR_LIMIT = 2'h3;

    // training interval unit is 2^8 clocks
    localparam int TRAIN_UNIT_SHIFT = 8;

    // register byte offsets
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_STATUS = 5'h04;
    localparam logic [4:0] REG_DATA_TRAIN_REPEATS = 5'h08;
    localparam logic [4:0] REG_STATUS_TRAIN_REPEATS = 5'h0c;
    localparam logic [4:0] REG_DATA_TRAIN_MAXT = 5'h10;
    localparam logic [4:0] REG_STATUS_TRAIN_MAXT = 5'h14;
    localparam logic [4:0] REG_CLASS_SEND = 5'h18;
    localparam logic [4:0] REG_CLASS_VIEW = 5'h1c;

    // control register fields
    localparam int CTRL_RUN = 0;
    localparam int CTRL_SNR_EN = 1;
    localparam int CTRL_SUBPORT_EN = 2;
    localparam int CTRL_MCAST_SEP = 3;
    localparam int CTRL_CLASS_EN = 4;
    localparam int CTRL_VIEW_GRP_LO = 8;
    localparam int CTRL_VIEW_MCAST = 12;
    localparam logic [12:0] CTRL_RST = 13'h0000;
    localparam logic [31:0] RDATA_NONE = 32'h00000000;

    typedef enum logic [2:0] {
        RX_RUN,
        RX_DIP_WAIT,
        RX_DIP_CONFIRM,
        RX_TRAIN,
        RX_TRAIN_END,
        RX_FRAME_LOST
    } fcs_rx_t;

    typedef struct packed {
        logic ready;
        logic [1:0] kind;
        logic [23:0] body;
    } fcs_msg_t;

    typedef struct packed {
        logic [4:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } fcs_avs_req_t;

    typedef struct packed {
        logic [39:0] cyc;
        logic [7:0] left;
        logic req;
    } fcs_sched_t;

endpackage

// ### fcs_flow_status.sv
// flow-control status handling for the data source in fabric mode
//
// Local design decisions: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/10ps

// How it works
// - idle messages carry type 11, zero bits 23:0, ready flag in 26
// - idle sent when nothing pending or remote status-not-ready holds
// - bit 26 is the ready flag: 1 accepts data, 0 refuses
// - class messages carry a zero type bit 25
// - bit 24 marks multicast only when unicast and multicast separate
// - sub-port bits sent zero unless sub-port mode is on; always ignored on receipt
// - bits 19:16 pick sixteen classes; bitmap bit i is XON for class
// - after reset ready is off, every other flow state is XON
// - all bursts stopped within C plus one segment of ticks
// - no new transfer starts once ready has been cleared
// - checksum checked first; error clears ready until two good msgs
// - training clears ready; afterwards follow first good message
// - third framing error clears ready until a checksum-valid message
// - class messages act in one cycle, as fast as per-port messages
// - status-not-ready driven zero unless the feature is enabled
// - status-not-ready set means only idle messages are accepted
// - sender follows status-not-ready changes on the next message
// - status-not-ready handling has its own enable bit
// - data training counts as not-ready; idle control word follows
// - ready flag of idle messages still honoured under not-ready
// - training repeats and intervals loaded by software before run
// - repeats 0..255 scheduled in every interval of 256 clocks units after the first
module fcs_flow_status
    import fcs_pkg::*;
#(
    parameter int SEG_TICKS = fcs_pkg::SEG_TICKS_DEF
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register bus
    input wire fcs_pkg::fcs_avs_req_t avsReq,
    output logic [31:0] avsReadData,
    output logic avsWaitRequest,
    // received status messages
    input wire logic rxMsgValid,
    input wire fcs_pkg::fcs_msg_t rxMsg,
    input wire logic rxDip2Ok,
    input wire logic rxTraining,
    input wire logic rxFrameErr,
    // data path gating
    input wire logic [7:0] segClass,
    input wire logic segMcast,
    input wire logic burstActive,
    output logic startAllowed,
    output logic classXon,
    output logic stopOverdue,
    // status sender
    input wire logic localReady,
    input wire logic localStatusBusy,
    input wire logic txTake,
    output fcs_pkg::fcs_msg_t txMsg,
    output logic txMsgValid,
    input wire logic icwValid,
    input wire logic icwSnrIn,
    input wire logic dataTrainRx,
    output logic icwSnrOut,
    output logic icwReq,
    // training scheduling
    output logic dataTrainReq,
    input wire logic dataTrainDone,
    output logic statTrainReq,
    input wire logic statTrainDone
);
    import fcs_pkg::*;

    localparam int RESP_CYC = (C_TICKS + SEG_TICKS) / TICKS_PER_CYCLE;
    localparam logic [7:0] RESP_CNT = 8'(RESP_CYC);

    typedef struct packed {
        logic waitReq;
        logic [31:0] readData;
        logic [12:0] ctrl;
        logic [7:0] dataRep;
        logic [7:0] statRep;
        logic [31:0] dataMaxT;
        logic [31:0] statMaxT;
        logic pend;
        logic [24:0] pendMsg;
        fcs_rx_t rxSt;
        logic drState;
        logic [1:0] frameErrCnt;
        logic [7:0] stopCnt;
        logic stopRun;
        logic startAllowed;
        logic stopOverdue;
        logic classXon;
        logic [1:0][15:0][15:0] classTbl;
        logic snrRemote;
        fcs_msg_t txMsg;
        logic txMsgValid;
        logic icwSnrOut;
        logic icwReq;
        fcs_sched_t dataSch;
        fcs_sched_t statSch;
    } fcs_state_t;

    fcs_state_t state_q;
    fcs_state_t state_d;

    function automatic fcs_sched_t schedStep(
        input fcs_sched_t s,
        input logic [7:0] rep,
        input logic [31:0] maxT,
        input logic run,
        input logic done
    );
        fcs_sched_t n;
        logic [39:0] lim;
        n = s;
        lim = {maxT, 8'h00};
        if (done && n.left != 8'h00)
        begin
            n.left = n.left - 8'h01;
        end
        if (!run || maxT == 32'h00000000)
        begin
            n.cyc = 40'h0000000000;
            n.left = 8'h00;
        end
        else if (n.cyc >= lim - 40'h0000000001)
        begin
            // a new interval reloads the full repeat count
            n.cyc = 40'h0000000000;
            n.left = rep;
        end
        else
        begin
            n.cyc = n.cyc + 40'h0000000001;
        end
        n.req = n.left != 8'h00;
        return n;
    endfunction

    logic rxGood;
    logic rxBad;
    logic [1:0] errNext;
    logic useMcast;
    assign rxGood = rxMsgValid && rxDip2Ok;
    assign rxBad = rxMsgValid && !rxDip2Ok;

    always_comb
    begin
        state_d = state_q;
        errNext = state_q.frameErrCnt;
        useMcast = 1'b0;

        // bus slave: one wait cycle, then the answer
        state_d.waitReq = !((avsReq.read || avsReq.write) && state_q.waitReq);
        if (avsReq.read && state_q.waitReq)
        begin
            if (avsReq.address == REG_CTRL)
            begin
                state_d.readData = {19'h00000, state_q.ctrl};
            end
            else if (avsReq.address == REG_STATUS)
            begin
                state_d.readData = {24'h000000, state_q.stopOverdue,
                    state_q.snrRemote, state_q.rxSt, state_q.startAllowed,
                    state_q.drState, state_q.pend};
            end
            else if (avsReq.address == REG_DATA_TRAIN_REPEATS)
            begin
                state_d.readData = {24'h000000, state_q.dataRep};
            end
            else if (avsReq.address == REG_STATUS_TRAIN_REPEATS)
            begin
                state_d.readData = {24'h000000, state_q.statRep};
            end
            else if (avsReq.address == REG_DATA_TRAIN_MAXT)
            begin
                state_d.readData = state_q.dataMaxT;
            end
            else if (avsReq.address == REG_STATUS_TRAIN_MAXT)
            begin
                state_d.readData = state_q.statMaxT;
            end
            else if (avsReq.address == REG_CLASS_SEND)
            begin
                state_d.readData = {7'h00, state_q.pendMsg};
            end
            else if (avsReq.address == REG_CLASS_VIEW)
            begin
                state_d.readData = {16'h0000, state_q.classTbl
                    [state_q.ctrl[CTRL_VIEW_MCAST]]
                    [state_q.ctrl[CTRL_VIEW_GRP_LO +: 4]]};
            end
            else
            begin
                state_d.readData = RDATA_NONE;
            end
        end

        // training counts are loaded here before run is set
        if (avsReq.write && !state_q.waitReq)
        begin
            if (avsReq.address == REG_CTRL)
            begin
                state_d.ctrl = avsReq.writedata[12:0];
            end
            else if (avsReq.address == REG_DATA_TRAIN_REPEATS)
            begin
                state_d.dataRep = avsReq.writedata[7:0];
            end
            else if (avsReq.address == REG_STATUS_TRAIN_REPEATS)
            begin
                state_d.statRep = avsReq.writedata[7:0];
            end
            else if (avsReq.address == REG_DATA_TRAIN_MAXT)
            begin
                state_d.dataMaxT = avsReq.writedata;
            end
            else if (avsReq.address == REG_STATUS_TRAIN_MAXT)
            begin
                state_d.statMaxT = avsReq.writedata;
            end
        end

        // training scheduler, one per path
        state_d.dataSch = schedStep(state_q.dataSch, state_q.dataRep,
            state_q.dataMaxT, state_q.ctrl[CTRL_RUN], dataTrainDone);
        state_d.statSch = schedStep(state_q.statSch, state_q.statRep,
            state_q.statMaxT, state_q.ctrl[CTRL_RUN], statTrainDone);

        // receiver: ready flag recovery
        if (rxFrameErr && !rxGood && errNext != FRAME_ERR_LIMIT)
        begin
            errNext = errNext + 2'h1;
        end
        else if (rxGood)
        begin
            errNext = 2'h0;
        end
        state_d.frameErrCnt = errNext;

        case (state_q.rxSt)
            RX_RUN:
            begin
                if (rxTraining)
                begin
                    state_d.rxSt = RX_TRAIN;
                end
                else if (rxGood)
                begin
                    state_d.drState = rxMsg.ready;
                end
                else if (rxBad)
                begin
                    state_d.rxSt = RX_DIP_WAIT;
                end
            end
            RX_DIP_WAIT:
            begin
                if (rxTraining)
                begin
                    state_d.rxSt = RX_TRAIN;
                end
                else if (rxGood)
                begin
                    state_d.rxSt = RX_DIP_CONFIRM;
                end
            end
            RX_DIP_CONFIRM:
            begin
                if (rxTraining)
                begin
                    state_d.rxSt = RX_TRAIN;
                end
                else if (rxGood)
                begin
                    state_d.drState = rxMsg.ready;
                    state_d.rxSt = RX_RUN;
                end
                else if (rxBad)
                begin
                    state_d.rxSt = RX_DIP_WAIT;
                end
            end
            RX_TRAIN:
            begin
                if (!rxTraining)
                begin
                    state_d.rxSt = RX_TRAIN_END;
                end
            end
            RX_TRAIN_END, RX_FRAME_LOST:
            begin
                if (rxTraining)
                begin
                    state_d.rxSt = RX_TRAIN;
                end
                else if (rxGood)
                begin
                    state_d.drState = rxMsg.ready;
                    state_d.rxSt = RX_RUN;
                end
                else if (rxBad)
                begin
                    // a bad checksum here still needs two good messages
                    state_d.rxSt = RX_DIP_WAIT;
                end
            end
            default:
            begin
                state_d.rxSt = RX_RUN;
            end
        endcase
        if (state_d.rxSt != RX_RUN && state_d.rxSt != RX_DIP_CONFIRM)
        begin
            state_d.drState = 1'b0;
        end
        if (errNext == FRAME_ERR_LIMIT && state_q.frameErrCnt != errNext)
        begin
            state_d.rxSt = RX_FRAME_LOST;
            state_d.drState = 1'b0;
        end

        // class table, applied at once to the segment gate
        if (rxGood && rxMsg.kind[1] == KIND_CLASS
            && state_q.ctrl[CTRL_CLASS_EN])
        begin
            useMcast = state_q.ctrl[CTRL_MCAST_SEP] && rxMsg.kind[0];
            // sub-port field is not used by this end
            state_d.classTbl[useMcast][rxMsg.body[19:16]] =
                rxMsg.body[15:0];
        end
        state_d.classXon = state_d.classTbl
            [state_q.ctrl[CTRL_MCAST_SEP] && segMcast]
            [segClass[7:4]][segClass[3:0]];
        // refusing new starts at once is stricter than the C allowance
        state_d.startAllowed = state_d.drState && state_d.classXon;

        // burst stop deadline from each loss of ready
        if (state_q.drState && !state_d.drState)
        begin
            state_d.stopRun = 1'b1;
            state_d.stopCnt = RESP_CNT;
        end
        else if (state_q.stopRun && state_q.stopCnt != 8'h00)
        begin
            state_d.stopCnt = state_q.stopCnt - 8'h01;
        end
        else if (state_q.stopRun)
        begin
            state_d.stopRun = 1'b0;
            state_d.stopOverdue = burstActive;
        end
        if (!burstActive)
        begin
            state_d.stopOverdue = 1'b0;
        end

        // remote status-not-ready, only when enabled
        if (!state_q.ctrl[CTRL_SNR_EN])
        begin
            state_d.snrRemote = 1'b0;
        end
        else if (dataTrainRx)
        begin
            state_d.snrRemote = 1'b1;
        end
        else if (icwValid)
        begin
            state_d.snrRemote = icwSnrIn;
        end

        // status sender
        state_d.txMsgValid = txTake;
        if (txTake)
        begin
            if (state_q.pend && !state_q.snrRemote)
            begin
                state_d.txMsg.ready = localReady;
                state_d.txMsg.kind = {KIND_CLASS,
                    state_q.ctrl[CTRL_MCAST_SEP] && state_q.pendMsg[24]};
                state_d.txMsg.body = {state_q.ctrl[CTRL_SUBPORT_EN] ?
                    state_q.pendMsg[23:20] : SUBPORT_NONE,
                    state_q.pendMsg[19:0]};
                state_d.pend = 1'b0;
            end
            else
            begin
                state_d.txMsg.ready = localReady;
                state_d.txMsg.kind = KIND_IDLE;
                state_d.txMsg.body = IDLE_BODY;
            end
        end
        // a new class write wins over the send that clears it
        if (avsReq.write && !state_q.waitReq
            && avsReq.address == REG_CLASS_SEND)
        begin
            state_d.pend = 1'b1;
            state_d.pendMsg = avsReq.writedata[24:0];
        end
        state_d.icwSnrOut = state_q.ctrl[CTRL_SNR_EN] && localStatusBusy;
        state_d.icwReq = dataTrainDone;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= '0;
            state_q.waitReq <= 1'b1;
            state_q.ctrl <= CTRL_RST;
            state_q.txMsg.kind <= KIND_IDLE;
            state_q.classTbl <= '1;
            state_q.classXon <= 1'b1;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign avsReadData = state_q.readData;
    assign avsWaitRequest = state_q.waitReq;
    assign startAllowed = state_q.startAllowed;
    assign classXon = state_q.classXon;
    assign stopOverdue = state_q.stopOverdue;
    assign txMsg = state_q.txMsg;
    assign txMsgValid = state_q.txMsgValid;
    assign icwSnrOut = state_q.icwSnrOut;
    assign icwReq = state_q.icwReq;
    assign dataTrainReq = state_q.dataSch.req;
    assign statTrainReq = state_q.statSch.req;

    sequence seqDipBad;
        rxBad && !rxTraining;
    endsequence

    sequence seqThirdFrameErr;
        state_q.frameErrCnt == 2'h2 && rxFrameErr && !rxGood;
    endsequence

    AST_IDLE_FORMAT: assert property (@(posedge ref_clk) disable iff (rst)
        txMsgValid && txMsg.kind == KIND_IDLE |-> txMsg.body == IDLE_BODY)
        else $error("idle message has nonzero reserved bits");
    AST_SNR_IDLE_ONLY: assert property (@(posedge ref_clk) disable iff (rst)
        txTake && state_q.snrRemote |=> txMsgValid && txMsg.kind == KIND_IDLE)
        else $error("non-idle message sent under status-not-ready");
    AST_SUBPORT_ZERO: assert property (@(posedge ref_clk) disable iff (rst)
        txTake && !state_q.ctrl[CTRL_SUBPORT_EN] |=> txMsg.body[23:20] == 4'h0)
        else $error("sub-port bits sent while sub-port mode is off");
    AST_DIP_CLEARS: assert property (@(posedge ref_clk) disable iff (rst)
        seqDipBad |=> !state_q.drState ##1 !state_q.drState)
        else $error("ready kept after checksum error");
    AST_TRAIN_CLEARS: assert property (@(posedge ref_clk) disable iff (rst)
        rxTraining |=> !state_q.drState && !startAllowed)
        else $error("ready kept during training");
    AST_FRAME_LOST: assert property (@(posedge ref_clk) disable iff (rst)
        seqThirdFrameErr |=> state_q.rxSt == RX_FRAME_LOST && !state_q.drState)
        else $error("third framing error did not clear ready");
    AST_NO_START: assert property (@(posedge ref_clk) disable iff (rst)
        !state_q.drState |-> !startAllowed)
        else $error("start allowed while ready is cleared");
    AST_STOP_DEADLINE: assert property (@(posedge ref_clk) disable iff (rst)
        state_q.stopRun && state_q.stopCnt == 8'h00 && burstActive
        && !(state_q.drState && !state_d.drState) |=> stopOverdue)
        else $error("overdue burst not flagged at deadline");
    AST_IDLE_READY: assert property (@(posedge ref_clk) disable iff (rst)
        state_q.rxSt == RX_RUN && state_q.snrRemote && rxGood && !rxTraining
        && !rxFrameErr |=> state_q.drState == $past(rxMsg.ready))
        else $error("ready flag ignored under status-not-ready");
    AST_BUS_ONE_WAIT: assert property (@(posedge ref_clk) disable iff (rst)
        (avsReq.read || avsReq.write) && avsWaitRequest |=> !avsWaitRequest)
        else $error("bus answer not given after one wait cycle");

endmodule

// ### fcs_fabric_model.sv
// fabric-side partner model driving the status channel
`timescale 1ns/10ps
module fcs_fabric_model
    import fcs_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // status channel toward the block
    output logic rxMsgValid,
    output fcs_pkg::fcs_msg_t rxMsg,
    output logic rxDip2Ok,
    output logic rxTraining,
    output logic rxFrameErr,
    // framer take strobe
    output logic txTake
);
    initial
    begin
        rxMsgValid = 1'b0;
        rxMsg = '0;
        rxDip2Ok = 1'b0;
        rxTraining = 1'b0;
        rxFrameErr = 1'b0;
        txTake = 1'b0;
    end

    // one message; ok low corrupts the checksum on purpose
    task automatic send(input logic rdy, input logic [1:0] kind,
        input logic [23:0] body, input logic ok);
        @(posedge ref_clk);
        rxMsgValid <= 1'b1;
        rxMsg <= '{rdy, kind, body};
        rxDip2Ok <= ok;
        @(posedge ref_clk);
        rxMsgValid <= 1'b0;
        // stale fields never repeat, so a late read shows up
        rxMsg <= ~rxMsg;
        rxDip2Ok <= ~ok;
    endtask

    task automatic train(input int n);
        @(posedge ref_clk);
        rxTraining <= 1'b1;
        repeat (n) @(posedge ref_clk);
        rxTraining <= 1'b0;
    endtask

    task automatic frameErr(input int n);
        repeat (n)
        begin
            @(posedge ref_clk);
            rxFrameErr <= 1'b1;
            @(posedge ref_clk);
            rxFrameErr <= 1'b0;
        end
    endtask

    task automatic take();
        @(posedge ref_clk);
        txTake <= 1'b1;
        @(posedge ref_clk);
        txTake <= 1'b0;
    endtask
endmodule

// ### tb_fabric_flow_control_status.sv
// self-checking bench for the fabric flow-control status block
`timescale 1ns/10ps
module tb_fabric_flow_control_status;
    import fcs_pkg::*;
    logic ref_clk, rst, avsWaitRequest, rxMsgValid, rxDip2Ok, rxTraining;
    logic rxFrameErr, segMcast, burstActive, startAllowed, classXon;
    logic stopOverdue, localReady, localStatusBusy, txTake, txMsgValid;
    logic icwValid, icwSnrIn, dataTrainRx, icwSnrOut, icwReq, dataTrainReq;
    logic dataTrainDone, statTrainReq, statTrainDone;
    logic [31:0] avsReadData;
    logic [7:0] segClass;
    logic [3:0] grp;
    logic [15:0] map;
    fcs_avs_req_t avsReq;
    fcs_msg_t rxMsg, txMsg;
    logic [31:0] expQ[$];
    int mismatches, n_compared, cycles;

    fcs_flow_status dut_u (.ref_clk(ref_clk), .rst(rst), .avsReq(avsReq),
        .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
        .rxMsgValid(rxMsgValid), .rxMsg(rxMsg), .rxDip2Ok(rxDip2Ok),
        .rxTraining(rxTraining), .rxFrameErr(rxFrameErr),
        .segClass(segClass), .segMcast(segMcast), .burstActive(burstActive),
        .startAllowed(startAllowed), .classXon(classXon),
        .stopOverdue(stopOverdue), .localReady(localReady),
        .localStatusBusy(localStatusBusy), .txTake(txTake), .txMsg(txMsg),
        .txMsgValid(txMsgValid), .icwValid(icwValid), .icwSnrIn(icwSnrIn),
        .dataTrainRx(dataTrainRx), .icwSnrOut(icwSnrOut), .icwReq(icwReq),
        .dataTrainReq(dataTrainReq), .dataTrainDone(dataTrainDone),
        .statTrainReq(statTrainReq), .statTrainDone(statTrainDone));

    fcs_fabric_model fab_u (.ref_clk(ref_clk), .rxMsgValid(rxMsgValid),
        .rxMsg(rxMsg), .rxDip2Ok(rxDip2Ok), .rxTraining(rxTraining),
        .rxFrameErr(rxFrameErr), .txTake(txTake));

    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // an empty queue yields unknowns, so a stray result mismatches
    function automatic logic [31:0] pop();
        return expQ.size() ? expQ.pop_front() : 'x;
    endfunction

    always @(posedge ref_clk)
    begin
        if (txMsgValid === 1'b1)
            check({5'h0, txMsg}, pop());
        if (avsWaitRequest === 1'b0 && avsReq.read === 1'b1)
            check(avsReadData, pop());
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            conclude();
        end
    end

    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic bus(input logic wr, input logic [4:0] a,
        input logic [31:0] d);
        @(posedge ref_clk);
        avsReq <= '{a, !wr, wr, d};
        do
            @(posedge ref_clk);
        while (avsWaitRequest !== 1'b0);
        avsReq <= '0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        expQ.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    task automatic idleChk(input logic rdy, input logic ok, input logic e);
        fab_u.send(rdy, KIND_IDLE, IDLE_BODY, ok);
        wt(3);
        check(startAllowed, e);
    endtask

    task automatic takeExp(input logic [31:0] e);
        expQ.push_back(e);
        fab_u.take();
        wt(2);
    endtask

    task automatic snrIn(input logic v);
        @(posedge ref_clk);
        icwValid <= 1'b1;
        icwSnrIn <= v;
        @(posedge ref_clk);
        icwValid <= 1'b0;
    endtask

    initial
    begin
        rst = 1'b1;
        avsReq = '0;
        segClass = 8'h00;
        segMcast = 1'b0;
        burstActive = 1'b0;
        localReady = 1'b1;
        localStatusBusy = 1'b0;
        icwValid = 1'b0;
        icwSnrIn = 1'b0;
        dataTrainRx = 1'b0;
        dataTrainDone = 1'b0;
        statTrainDone = 1'b0;
        mismatches = 0;
        n_compared = 0;
        cycles = 0;
        void'($urandom(32'hd374d55a));
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        wt(1);
        check(startAllowed, 1'b0);
        check(classXon, 1'b1);
        $display("test reset done");
        bus(1'b1, REG_DATA_TRAIN_REPEATS, 32'h2);
        bus(1'b1, REG_DATA_TRAIN_MAXT, 32'h1);
        bus(1'b1, REG_CTRL, 32'h11);
        rd(REG_CTRL, 32'h11);
        rd(5'h1e, 32'h0);
        rd(REG_DATA_TRAIN_REPEATS, 32'h2);
        for (int i = 0; i < 600 && dataTrainReq !== 1'b1; i++)
            wt(1);
        check(dataTrainReq, 1'b1);
        repeat (2)
        begin
            @(posedge ref_clk);
            dataTrainDone <= 1'b1;
            @(posedge ref_clk);
            dataTrainDone <= 1'b0;
            #1 check(icwReq, 1'b1);
        end
        wt(2);
        check(dataTrainReq, 1'b0);
        $display("test registers and training done");
        idleChk(1'b1, 1'b1, 1'b1);
        idleChk(1'b1, 1'b0, 1'b0);
        idleChk(1'b1, 1'b1, 1'b0);
        idleChk(1'b1, 1'b1, 1'b1);
        fab_u.train(20);
        wt(3);
        check(startAllowed, 1'b0);
        idleChk(1'b1, 1'b1, 1'b1);
        fab_u.frameErr(3);
        wt(3);
        check(startAllowed, 1'b0);
        idleChk(1'b1, 1'b1, 1'b1);
        $display("test ready tracking done");
        @(posedge ref_clk);
        burstActive <= 1'b1;
        idleChk(1'b0, 1'b1, 1'b0);
        wt(100);
        check(stopOverdue, 1'b0);
        wt(20);
        check(stopOverdue, 1'b1);
        @(posedge ref_clk);
        burstActive <= 1'b0;
        wt(2);
        check(stopOverdue, 1'b0);
        $display("test stop deadline done");
        grp = 4'($urandom);
        map = 16'($urandom);
        @(posedge ref_clk);
        localStatusBusy <= 1'b1;
        wt(2);
        check(icwSnrOut, 1'b0);
        bus(1'b1, REG_CTRL, 32'h13);
        wt(2);
        check(icwSnrOut, 1'b1);
        snrIn(1'b1);
        bus(1'b1, REG_CLASS_SEND, {7'h0, 1'b1, 4'ha, grp, map});
        takeExp({5'h0, 1'b1, KIND_IDLE, IDLE_BODY});
        idleChk(1'b0, 1'b1, 1'b0);
        idleChk(1'b1, 1'b1, 1'b1);
        snrIn(1'b0);
        takeExp({5'h0, 2'b10, 1'b0, SUBPORT_NONE, grp, map});
        takeExp({5'h0, 1'b1, KIND_IDLE, IDLE_BODY});
        $display("test sender done");
        fab_u.send(1'b1, {KIND_CLASS, 1'b0}, {SUBPORT_NONE, grp, map}, 1'b1);
        for (int i = 0; i < 16; i++)
        begin
            @(posedge ref_clk);
            segClass <= {grp, 4'(i)};
            wt(3);
            check(classXon, map[i]);
            check(startAllowed, map[i]);
        end
        $display("test class table done");
        check(expQ.size(), 32'h0);
        conclude();
    end
endmodule
